// File: core/serial_port_pkg.sv
package serial_port_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_ASYNC_MODE = 16'hFF70;
  localparam logic [15:0] IDX_ERR_STATUS = 16'hFF71;
  localparam logic [15:0] IDX_CLK_MODE   = 16'hFF72;
  localparam logic [15:0] IDX_DATA       = 16'hFF74;
  localparam int          ADDR_LSB       = 2;
  localparam int          ADDR_MSB       = 17;

  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  TXD_RESET      = 8'hFF;
  localparam logic [7:0]  AM_WMASK       = 8'hFC;
  localparam logic [7:0]  CM_WMASK       = 8'h86;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AM_TXE  = 7;
  localparam int AM_RXE  = 6;
  localparam int AM_PS_H = 5;
  localparam int AM_PS_L = 4;
  localparam int AM_CL   = 3;
  localparam int AM_SL   = 2;
  localparam int CM_EN   = 7;
  localparam int CM_DIR  = 2;
  localparam int CM_CSCK = 1;
  localparam int ES_PE   = 2;
  localparam int ES_FE   = 1;
  localparam int ES_OVE  = 0;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  localparam logic [3:0] BITS_LONG  = 4'h8;
  localparam logic [3:0] BITS_SHORT = 4'h7;
  localparam logic [3:0] FRAME_OVH  = 4'h2;
  localparam logic [3:0] SHIFT_LEN  = 4'h8;

  typedef struct packed {
    logic       txe;
    logic       rxe;
    logic [1:0] ps;
    logic       cl;
    logic       sl;
    logic       en;
    logic       dir;
    logic       csck;
  } ctl_s;

  typedef struct packed {
    logic [7:0] data;
    logic       pe;
    logic       fe;
  } rx_word_s;

  typedef struct packed {
    logic [11:0] bits;
    logic [3:0]  len;
  } frame_s;

  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_e;

  function automatic logic [7:0] bit_rev(input logic [7:0] d);
    for (int i = 0; i < 8; i++) bit_rev[i] = d[7-i];
  endfunction : bit_rev

  function automatic logic par_calc(input logic [7:0] d, input logic [1:0] ps);
    case (ps)
      PAR_ODD:  par_calc = ~^d;
      PAR_EVEN: par_calc = ^d;
      default:  par_calc = 1'b0;
    endcase
  endfunction : par_calc

  // Sent LSB first from bit 0; ones above the data act as stop bits
  function automatic frame_s frame_build(input logic [7:0] d, input ctl_s c);
    logic [7:0] dm;
    dm = c.cl ? d : {1'b0, d[6:0]};
    frame_build.bits = {3'h7, ~c.cl | d[7], d[6:0], 1'b0};
    if (c.ps != PAR_NONE) frame_build.bits[c.cl ? 9 : 8] = par_calc(dm, c.ps);
    frame_build.len = (c.cl ? BITS_LONG : BITS_SHORT) + FRAME_OVH
                      + {3'h0, c.ps != PAR_NONE} + {3'h0, c.sl};
  endfunction : frame_build

endpackage : serial_port_pkg

// File: core/serial_port_ctrl.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps

// What this block does
// - Reset clears clocked-mode control register
// - Reset clears async-mode control register
// - Clocked enable bit gates 3-wire transfers
// - Clock select: pin input or driven out
// - Async register field layout as specified
// - Transmit and receive enables act independently
// - Parity: none, zero, odd, even
// - Stop length: one or two bits
// - Receiver records error kinds in status
// - Control registers accept bit and byte writes
// - Seven-bit characters keep bit seven zero
// - Status: parity, framing, overrun; one stop
module serial_port_ctrl
  import serial_port_pkg::*;
(
  input  logic        CLOCK,
  input  logic        RST_N,
  input  logic        LINK_CLK,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [31:0] PADDR,
  input  logic [31:0] PWDATA,
  input  logic [3:0]  PSTRB,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic        SERIAL_IN,
  output logic        SERIAL_OUT,
  output logic        SCK_O,
  output logic        SCK_OE_N
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  am;
    logic [7:0]  cm;
    logic [7:0]  es;
    logic [7:0]  rxb;
    logic [7:0]  txd;
    logic        tx_tgl;
    logic        rx_full;
    logic        ack_s1;
    logic        ack_s2;
    logic        rxt_s1;
    logic        rxt_s2;
    logic        rxt_d;
    logic [31:0] prdata;
    logic        pslverr;
  } cpu_s;

  typedef struct packed {
    ctl_s        ctl_s1;
    ctl_s        ctl_s2;
    logic        req_s1;
    logic        req_s2;
    logic        req_d;
    logic        ack_tgl;
    logic        rxd_s1;
    logic        rxd_s2;
    logic [11:0] tx_bits;
    logic [3:0]  tx_cnt;
    logic        ph;
    logic        sck;
    logic        sck_oe_n;
    logic        so;
    rx_state_e   rx_state;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic        rx_par;
    logic        rx_tgl;
    logic [1:0]  smp_d;
    logic [1:0]  last_d;
    rx_word_s    rx_word;
  } link_s;

  cpu_s  c_r, c_nxt;
  link_s l_r, l_nxt;
  ctl_s  ctl;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [15:0] idx;
  logic        mapped;
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;
  logic        busy;
  logic        rx_arrive;

  assign idx       = PADDR[ADDR_MSB:ADDR_LSB];
  assign mapped    = (PADDR[31:ADDR_MSB+1] == '0) && (PADDR[ADDR_LSB-1:0] == '0)
                     && (idx == IDX_ASYNC_MODE || idx == IDX_ERR_STATUS
                         || idx == IDX_CLK_MODE || idx == IDX_DATA);
  assign setup     = PSEL && !PENABLE;
  assign wr_acc    = PSEL && PENABLE && PWRITE && PSTRB[0] && mapped;
  assign rd_acc    = PSEL && PENABLE && !PWRITE && mapped;
  assign busy      = c_r.tx_tgl != c_r.ack_s2;
  assign rx_arrive = c_r.rxt_s2 != c_r.rxt_d;
  assign PREADY    = 1'b1;
  assign PRDATA    = c_r.prdata;
  assign PSLVERR   = c_r.pslverr;

  assign ctl = '{txe: c_r.am[AM_TXE], rxe: c_r.am[AM_RXE],
                 ps: c_r.am[AM_PS_H:AM_PS_L], cl: c_r.am[AM_CL], sl: c_r.am[AM_SL],
                 en: c_r.cm[CM_EN], dir: c_r.cm[CM_DIR], csck: c_r.cm[CM_CSCK]};

  // ----------------------------------------------------------------
  // Processor side
  // ----------------------------------------------------------------
  always_comb begin
    c_nxt        = c_r;
    c_nxt.ack_s1 = l_r.ack_tgl;
    c_nxt.ack_s2 = c_r.ack_s1;
    c_nxt.rxt_s1 = l_r.rx_tgl;
    c_nxt.rxt_s2 = c_r.rxt_s1;
    c_nxt.rxt_d  = c_r.rxt_s2;
    if (setup) begin
      c_nxt.pslverr = !mapped;
      case (idx)
        IDX_ASYNC_MODE: c_nxt.prdata = {24'h0, c_r.am};
        IDX_ERR_STATUS: c_nxt.prdata = {24'h0, c_r.es};
        IDX_CLK_MODE:   c_nxt.prdata = {24'h0, c_r.cm};
        IDX_DATA:       c_nxt.prdata = {24'h0, c_r.rxb};
        default:        c_nxt.prdata = 32'h0;
      endcase
      if (!mapped) c_nxt.prdata = 32'h0;
    end
    // written byte is masked to the writable bits; a bit write is a read-modify-write
    if (wr_acc) begin
      case (idx)
        IDX_ASYNC_MODE: c_nxt.am = PWDATA[7:0] & AM_WMASK;
        IDX_CLK_MODE:   c_nxt.cm = PWDATA[7:0] & CM_WMASK;
        IDX_DATA: begin
          // A write during a transfer is dropped rather than corrupt it
          if (!busy) begin
            c_nxt.txd    = PWDATA[7:0];
            c_nxt.tx_tgl = ~c_r.tx_tgl;
          end
        end
        default: ;
      endcase
    end
    // Clears first so that a same-cycle arrival wins
    if (rd_acc && idx == IDX_ERR_STATUS) c_nxt.es = CTRL_RESET;
    if (rd_acc && idx == IDX_DATA) c_nxt.rx_full = 1'b0;
    if (rx_arrive) begin
      c_nxt.rxb     = l_r.rx_word.data;
      c_nxt.rx_full = 1'b1;
      c_nxt.es[ES_PE] = c_nxt.es[ES_PE] | l_r.rx_word.pe;
      c_nxt.es[ES_FE] = c_nxt.es[ES_FE] | l_r.rx_word.fe;
      if (c_r.rx_full && !(rd_acc && idx == IDX_DATA)) c_nxt.es[ES_OVE] = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      c_r     <= '0;
      c_r.am  <= CTRL_RESET;
      c_r.cm  <= CTRL_RESET;
      c_r.es  <= CTRL_RESET;
      c_r.txd <= TXD_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  logic [3:0] nbits;
  logic       req_edge;
  logic [7:0] rx_data;
  logic [7:0] sh_in;

  assign nbits    = l_r.ctl_s2.cl ? BITS_LONG : BITS_SHORT;
  assign req_edge = l_r.req_s2 != l_r.req_d;
  // bit seven forced low for short characters
  assign rx_data  = l_r.ctl_s2.cl ? l_r.rx_sh : {1'b0, l_r.rx_sh[7:1]};
  assign sh_in    = {l_r.rxd_s2, l_r.rx_sh[7:1]};

  always_comb begin
    l_nxt          = l_r;
    l_nxt.ctl_s1   = ctl;
    l_nxt.ctl_s2   = l_r.ctl_s1;
    l_nxt.req_s1   = c_r.tx_tgl;
    l_nxt.req_s2   = l_r.req_s1;
    l_nxt.req_d    = l_r.req_s2;
    l_nxt.rxd_s1   = SERIAL_IN;
    l_nxt.rxd_s2   = l_r.rxd_s1;
    l_nxt.smp_d    = {l_r.smp_d[0], 1'b0};
    l_nxt.last_d   = {l_r.last_d[0], 1'b0};
    // drive the clock pin only for the internal source
    l_nxt.sck_oe_n = !(l_r.ctl_s2.en && l_r.ctl_s2.csck);
    if (req_edge) begin
      if (l_r.ctl_s2.en) begin
        l_nxt.tx_bits = {4'hF, l_r.ctl_s2.dir ? c_r.txd : bit_rev(c_r.txd)};
        l_nxt.tx_cnt  = SHIFT_LEN;
        l_nxt.ph      = 1'b0;
      end else if (l_r.ctl_s2.txe) begin
        {l_nxt.tx_bits, l_nxt.tx_cnt} = frame_build(c_r.txd, l_r.ctl_s2);
      end else begin
        l_nxt.ack_tgl = ~l_r.ack_tgl;
      end
    end else if (l_r.tx_cnt != 4'h0) begin
      if (!l_r.ctl_s2.en) begin
        l_nxt.so      = l_r.tx_bits[0];
        l_nxt.tx_bits = l_r.tx_bits >> 1;
        l_nxt.tx_cnt  = l_r.tx_cnt - 4'h1;
      end else if (!l_r.ph) begin
        l_nxt.so      = l_r.tx_bits[0];
        l_nxt.tx_bits = l_r.tx_bits >> 1;
        l_nxt.sck     = 1'b0;
        l_nxt.ph      = 1'b1;
      end else begin
        // Pin level at this edge leaves the synchroniser two edges later
        l_nxt.smp_d[0]  = 1'b1;
        l_nxt.last_d[0] = l_r.tx_cnt == 4'h1;
        l_nxt.sck       = 1'b1;
        l_nxt.ph        = 1'b0;
        l_nxt.tx_cnt    = l_r.tx_cnt - 4'h1;
      end
      if (l_nxt.tx_cnt == 4'h0) l_nxt.ack_tgl = ~l_r.ack_tgl;
    end
    if (l_r.smp_d[1]) begin
      l_nxt.rx_sh = sh_in;
      if (l_r.last_d[1]) begin
        // received order follows the same bit
        l_nxt.rx_word = '{data: l_r.ctl_s2.dir ? sh_in : bit_rev(sh_in), pe: 1'b0, fe: 1'b0};
        l_nxt.rx_tgl  = ~l_r.rx_tgl;
      end
    end
    // receiver runs on its own enable while clocked mode is off
    case (l_r.rx_state)
      RX_IDLE: begin
        if (!l_r.rxd_s2) begin
          l_nxt.rx_state = RX_DATA;
          l_nxt.rx_cnt   = 4'h0;
        end
      end
      RX_DATA: begin
        l_nxt.rx_sh  = sh_in;
        l_nxt.rx_cnt = l_r.rx_cnt + 4'h1;
        if (l_r.rx_cnt == nbits - 4'h1)
          l_nxt.rx_state = (l_r.ctl_s2.ps != PAR_NONE) ? RX_PAR : RX_STOP;
      end
      RX_PAR: begin
        l_nxt.rx_par   = l_r.rxd_s2;
        l_nxt.rx_state = RX_STOP;
      end
      RX_STOP: begin
        // one stop bit checked; zero-parity mode never checks
        l_nxt.rx_word.data = rx_data;
        l_nxt.rx_word.fe   = !l_r.rxd_s2;
        l_nxt.rx_word.pe   = l_r.ctl_s2.ps[1]
                             && (l_r.rx_par != par_calc(rx_data, l_r.ctl_s2.ps));
        l_nxt.rx_tgl       = ~l_r.rx_tgl;
        l_nxt.rx_state     = RX_IDLE;
      end
      default: l_nxt.rx_state = RX_IDLE;
    endcase
    if (!l_r.ctl_s2.rxe || l_r.ctl_s2.en) l_nxt.rx_state = RX_IDLE;
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      l_r          <= '0;
      l_r.so       <= 1'b1;
      l_r.sck      <= 1'b1;
      l_r.sck_oe_n <= 1'b1;
      l_r.rxd_s1   <= 1'b1;
      l_r.rxd_s2   <= 1'b1;
      l_r.rx_state <= RX_IDLE;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign SERIAL_OUT = l_r.so;
  assign SCK_O      = l_r.sck;
  assign SCK_OE_N   = l_r.sck_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cm_reset;
    @(posedge CLOCK) disable iff (!RST_N) $rose(RST_N) |-> c_r.cm == CTRL_RESET;
  endproperty
  a_cm_reset: assert property (p_cm_reset) else $error("clocked mode not clear");

  property p_am_reset;
    @(posedge CLOCK) disable iff (!RST_N) $rose(RST_N) |-> c_r.am == CTRL_RESET;
  endproperty
  a_am_reset: assert property (p_am_reset) else $error("async mode not clear");

  property p_am_write;
    @(posedge CLOCK) disable iff (!RST_N)
      (wr_acc && idx == IDX_ASYNC_MODE) |=> c_r.am == ($past(PWDATA[7:0]) & AM_WMASK);
  endproperty
  a_am_write: assert property (p_am_write) else $error("async write lost");

  property p_clk_len;
    @(posedge LINK_CLK) disable iff (!RST_N) (req_edge && l_r.ctl_s2.en) |=> l_r.tx_cnt == SHIFT_LEN;
  endproperty
  a_clk_len: assert property (p_clk_len) else $error("clocked length wrong");

  property p_idle_tx;
    @(posedge LINK_CLK) disable iff (!RST_N)
      (req_edge && !l_r.ctl_s2.en && !l_r.ctl_s2.txe) |=> (l_r.tx_cnt == 4'h0) [*2];
  endproperty
  a_idle_tx: assert property (p_idle_tx) else $error("disabled transmitter ran");

  property p_frame_len;
    @(posedge LINK_CLK) disable iff (!RST_N)
      (req_edge && !l_r.ctl_s2.en && l_r.ctl_s2.txe && l_r.ctl_s2.cl && l_r.ctl_s2.sl
       && l_r.ctl_s2.ps == PAR_NONE) |=> l_r.tx_cnt == (BITS_LONG + FRAME_OVH + 4'h1);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("two stop bits missing");

  property p_short_char;
    @(posedge LINK_CLK) disable iff (!RST_N)
      (l_r.rx_state == RX_STOP && !l_r.ctl_s2.cl) |=> !l_r.rx_word.data[7];
  endproperty
  a_short_char: assert property (p_short_char) else $error("bit seven set");

  property p_zero_par;
    @(posedge LINK_CLK) disable iff (!RST_N)
      (l_r.rx_state == RX_STOP && l_r.ctl_s2.ps == PAR_ZERO) |=> !l_r.rx_word.pe;
  endproperty
  a_zero_par: assert property (p_zero_par) else $error("parity checked in zero mode");

  property p_overrun;
    @(posedge CLOCK) disable iff (!RST_N)
      (rx_arrive && c_r.rx_full && !rd_acc) |=> c_r.es[ES_OVE] ##1 c_r.rx_full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_sck_drive;
    @(posedge LINK_CLK) disable iff (!RST_N)
      (l_r.ctl_s2.en && l_r.ctl_s2.csck) |=> !SCK_OE_N;
  endproperty
  a_sck_drive: assert property (p_sck_drive) else $error("clock pin not driven");

  c_uart_tx:  cover property (@(posedge LINK_CLK) req_edge && l_r.ctl_s2.txe);
  c_clk_xfer: cover property (@(posedge LINK_CLK) req_edge && l_r.ctl_s2.en);
  c_overrun:  cover property (@(posedge CLOCK) rx_arrive && c_r.rx_full);

endmodule : serial_port_ctrl

// File: verif/serial_peer.sv
`timescale 1ns/1ps

module serial_peer (
  input  wire logic LINK_CLK,
  input  wire logic SERIAL_OUT,
  input  wire logic SCK_O,
  output logic      SERIAL_IN
);
  // ------------------------------------------
  // Remote end; the line idles high
  // ------------------------------------------
  initial SERIAL_IN = 1'b1;

  // Change on the falling edge, away from the sampling edge
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge LINK_CLK);
      SERIAL_IN = b[i];
    end
    @(negedge LINK_CLK);
    SERIAL_IN = 1'b1;
  endtask : send

  task automatic grab(output logic [11:0] b, input int n);
    b = 12'hFFF;
    do @(negedge LINK_CLK); while (SERIAL_OUT !== 1'b0);
    b[0] = 1'b0;
    for (int i = 1; i < n; i++) begin
      @(negedge LINK_CLK);
      b[i] = SERIAL_OUT;
    end
  endtask : grab

  // First bit out first; data change while the clock is low
  task automatic xfer(input logic [7:0] s, output logic [7:0] g);
    g = 8'h00;
    SERIAL_IN = s[7];
    for (int i = 0; i < 8; i++) begin
      @(posedge SCK_O);
      g = {g[6:0], SERIAL_OUT};
      if (i < 7) begin
        @(negedge SCK_O);
        SERIAL_IN = s[6-i];
      end
    end
    // Released line must not keep showing the last bit
    repeat (2) @(negedge LINK_CLK);
    SERIAL_IN = ~SERIAL_IN;
  endtask : xfer

endmodule : serial_peer

// File: verif/dual_mode_serial_port_control_bench.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end \
end

module dual_mode_serial_port_control_bench
  import serial_port_pkg::*;
;
  logic        CLOCK, RST_N, LINK_CLK, PSEL, PENABLE, PWRITE;
  logic [31:0] PADDR, PWDATA, PRDATA;
  logic [3:0]  PSTRB;
  logic        PREADY, PSLVERR, SERIAL_IN, SERIAL_OUT, SCK_O, SCK_OE_N;
  int          failures, check_count;
  logic [7:0]  rd;
  logic        err;

  serial_port_ctrl serial_port_ctrl_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .LINK_CLK(LINK_CLK), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT), .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N)
  );

  serial_peer serial_peer_inst (
    .LINK_CLK(LINK_CLK), .SERIAL_OUT(SERIAL_OUT), .SCK_O(SCK_O), .SERIAL_IN(SERIAL_IN)
  );

  initial begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end

  initial begin
    LINK_CLK = 1'b0;
    #7;
    forever #62.5 LINK_CLK = ~LINK_CLK;
  end

  // ------------------------------------------
  // Helpers
  // ------------------------------------------
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge CLOCK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= {14'h0, idx, 2'h0};
    PWDATA <= {24'h0, wd};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA[7:0];
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Frame LSB first from bit 0, length in the top nibble
  function automatic logic [15:0] mk(input logic [7:0] d, input logic [7:0] am);
    logic [11:0] b;
    logic [7:0]  dm;
    int          n;
    b = 12'hFFF;
    b[0] = 1'b0;
    dm = am[3] ? d : {1'b0, d[6:0]};
    n = am[3] ? 9 : 8;
    for (int i = 1; i < n; i++) b[i] = dm[i-1];
    if (am[5:4] != 2'h0) begin
      b[n] = am[5] & (^dm ^ ~am[4]);
      n++;
    end
    mk = {4'(n + 1 + am[2]), b};
  endfunction : mk

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction : rev

  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_regs;
    apb(1'b0, IDX_ASYNC_MODE, 8'h00);
    `CHK("async reset", 8'h00, rd)
    apb(1'b0, IDX_CLK_MODE, 8'h00);
    `CHK("clocked reset", 8'h00, rd)
    `CHK("pins at reset", 3'h7, {SERIAL_OUT, SCK_O, SCK_OE_N})
    apb(1'b1, IDX_ASYNC_MODE, 8'hFC);
    apb(1'b0, IDX_ASYNC_MODE, 8'h00);
    `CHK("async fields", 8'hFC, rd)
    apb(1'b1, IDX_ASYNC_MODE, 8'h00);
    apb(1'b1, IDX_CLK_MODE, 8'h86);
    apb(1'b0, IDX_CLK_MODE, 8'h00);
    `CHK("clocked fields", 8'h86, rd)
    apb(1'b1, IDX_CLK_MODE, 8'h00);
    apb(1'b0, 16'hFF73, 8'h00);
    `CHK("unmapped", 9'h100, {err, rd})
  endtask : t_regs

  task automatic t_idle;
    int lows;
    lows = 0;
    apb(1'b1, IDX_ASYNC_MODE, 8'h08);
    apb(1'b1, IDX_DATA, 8'h00);
    repeat (24) begin
      @(negedge LINK_CLK);
      lows += (SERIAL_OUT !== 1'b1) + (SCK_O !== 1'b1);
    end
    `CHK("idle line", 0, lows)
  endtask : t_idle

  task automatic t_tx;
    logic [7:0]  am [5] = '{8'h88, 8'h9C, 8'hA8, 8'hB4, 8'h80};
    logic [7:0]  dt [5] = '{8'hA5, 8'h3C, 8'h81, 8'hD3, 8'hFF};
    logic [15:0] f;
    logic [11:0] g;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, IDX_ASYNC_MODE, am[i]);
      f = mk(dt[i], am[i]);
      fork
        serial_peer_inst.grab(g, int'(f[15:12]));
        apb(1'b1, IDX_DATA, dt[i]);
      join
      `CHK("tx frame", f[11:0], g)
      repeat (20) @(posedge CLOCK);
    end
  endtask : t_tx

  task automatic t_rx;
    logic [7:0]  am [6] = '{8'h48, 8'h70, 8'h78, 8'h58, 8'h48, 8'h6C};
    logic [11:0] fl [6] = '{12'h0, 12'h0, 12'h200, 12'h200, 12'h200, 12'h0};
    logic [7:0]  es [6] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00};
    logic [15:0] f;
    logic [7:0]  d;
    for (int i = 0; i < 6; i++) begin
      d = 8'hC5 ^ 8'(i);
      f = mk(d, am[i]);
      apb(1'b1, IDX_ASYNC_MODE, am[i]);
      serial_peer_inst.send(f[11:0] ^ fl[i], int'(f[15:12]));
      repeat (10) @(posedge CLOCK);
      apb(1'b0, IDX_DATA, 8'h00);
      `CHK("rx data", (am[i][3] ? d : {1'b0, d[6:0]}), rd)
      apb(1'b0, IDX_ERR_STATUS, 8'h00);
      `CHK("rx status", es[i], rd)
    end
  endtask : t_rx

  task automatic t_overrun;
    logic [15:0] f;
    f = mk(8'h3A, 8'h48);
    apb(1'b1, IDX_ASYNC_MODE, 8'h48);
    repeat (2) serial_peer_inst.send(f[11:0], int'(f[15:12]));
    repeat (10) @(posedge CLOCK);
    apb(1'b0, IDX_ERR_STATUS, 8'h00);
    `CHK("overrun", 8'h01, rd)
    apb(1'b0, IDX_ERR_STATUS, 8'h00);
    `CHK("status cleared", 8'h00, rd)
    apb(1'b0, IDX_DATA, 8'h00);
    `CHK("rx data", 8'h3A, rd)
  endtask : t_overrun

  task automatic t_clocked;
    logic [7:0] cm [2] = '{8'h82, 8'h86};
    logic [7:0] g;
    apb(1'b1, IDX_ASYNC_MODE, 8'h00);
    apb(1'b1, IDX_CLK_MODE, 8'h80);
    repeat (4) @(negedge LINK_CLK);
    `CHK("clock pin input", 1'b1, SCK_OE_N)
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, IDX_CLK_MODE, cm[i]);
      repeat (4) @(negedge LINK_CLK);
      `CHK("clock pin driven", 1'b0, SCK_OE_N)
      fork
        serial_peer_inst.xfer(8'h6B, g);
        apb(1'b1, IDX_DATA, 8'hC1);
      join
      `CHK("clocked tx", (cm[i][2] ? rev(8'hC1) : 8'hC1), g)
      repeat (10) @(posedge CLOCK);
      apb(1'b0, IDX_DATA, 8'h00);
      `CHK("clocked rx", (cm[i][2] ? rev(8'h6B) : 8'h6B), rd)
    end
    apb(1'b1, IDX_CLK_MODE, 8'h00);
  endtask : t_clocked

  // ------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------
  initial begin
    {PSEL, PENABLE, PWRITE} = 3'h0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    PSTRB = 4'hF;
    RST_N = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_regs();
    t_idle();
    t_tx();
    t_rx();
    t_overrun();
    t_clocked();
    close_out();
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (40000) @(posedge CLOCK);
    failures++;
    close_out();
  end

endmodule : dual_mode_serial_port_control_bench
